// file: core/ureb_pkg.sv
// Shared constants and types of the serial receive-error, break and baud generator block.
package ureb_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on the APB side)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_MODE   = 12'h000;  // serial_mode_reg
    localparam logic [11:0] OFF_ERRST  = 12'h004;  // rx_error_status_reg
    localparam logic [11:0] OFF_CTRL   = 12'h008;  // serial_control_reg
    localparam logic [11:0] OFF_CKSEL  = 12'h00c;  // clock_select_reg
    localparam logic [11:0] OFF_BAUD   = 12'h010;  // baud_divider_reg
    localparam logic [11:0] OFF_RXBUF  = 12'h014;  // rx_buffer
    localparam logic [11:0] OFF_TXBUF  = 12'h018;  // tx_buffer

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned MODE_POWER_BIT = 7;
    localparam int unsigned MODE_TXE_BIT   = 6;
    localparam int unsigned MODE_RXE_BIT   = 5;
    localparam int unsigned MODE_PAR_LSB   = 3;   // Two bits: parity mode.
    localparam int unsigned MODE_MERGE_BIT = 0;   // error_irq_merge_sel.
    localparam int unsigned CTRL_FLAG_BIT  = 7;   // break_rx_flag, read only.
    localparam int unsigned CTRL_TRIG_BIT  = 6;   // break_rx_trigger.

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] MODE_RST   = 8'h00;
    localparam logic [3:0] CKSEL_RST  = 4'h0;
    localparam logic [7:0] BAUD_RST   = 8'hff;
    localparam logic [7:0] RXBUF_RST  = 8'hff;
    localparam logic [3:0] CKSEL_MAX  = 4'ha;    // Largest prescaler tap, clk/1024.
    localparam int unsigned PRESC_W   = 11;
    localparam logic [2:0] DATA_LAST  = 3'h7;    // Eight data bits per frame.

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        UREB_PAR_NONE = 2'h0,
        UREB_PAR_ZERO = 2'h1,
        UREB_PAR_ODD  = 2'h2,
        UREB_PAR_EVEN = 2'h3
    } ureb_parity_t;

    typedef struct packed {
        logic parity;   // Bit 2.
        logic framing;  // Bit 1.
        logic overrun;  // Bit 0.
    } ureb_err_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b011,
        RX_PAR   = 3'b010,
        RX_STOP  = 3'b110,
        RX_BRKW  = 3'b111
    } ureb_rxstate_t;

endpackage

// file: core/ureb_baud_counter.sv
// Programmable divider counter used for both the transmit and the receive baud timing.
`timescale 1ns/1ps
module ureb_baud_counter #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clear,
    input  wire logic             run,
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] divisor,
    output logic      [WIDTH-1:0] count,
    output logic                  wrap
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    // ------------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------------
    // One wrap is one half bit; two wraps make the 2*k base-clock bit period.
    assign wrap    = run && tick && !clear && (count_q == divisor - WIDTH'(1));
    assign count_d = (clear || wrap) ? '0 : (run && tick) ? count_q + WIDTH'(1) : count_q;
    assign count   = count_q;

    // Clear has priority so a disabled counter sits at zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule

// file: core/ureb_top.sv
// Receive error handling, noise filter, break field reception and baud generator with APB.
`timescale 1ns/1ps
// Behaviour
// (RULE1) Flag parity error when received parity mismatches configured parity.
// (RULE2) Flag framing error when the stop bit is sampled low.
// (RULE3) Flag overrun when a frame completes while the buffer is unread.
// (RULE4) Any error set at frame end raises a reception error interrupt.
// (RULE5) Reading the error status register clears it to zero.
// (RULE6) Merge select 0 uses separate error interrupt; 1 reports via completion.
// (RULE7) Input sampled on base clock; filter changes only when two samples agree.
// (RULE8) Receive processing lags the pin by two base-clock cycles.
// (RULE9) Software sends break as byte 00H, 8 bits, zero or even parity.
// (RULE10) Software stretches break by loading 1.3 times the divider.
// (RULE11) Break trigger accepted only after power and receive are enabled.
// (RULE12) Break reception detects start bit and shifts data as normally.
// (RULE13) Low width 11 bits or more: completion interrupt, flag and trigger cleared.
// (RULE14) During break reception overrun, parity and framing detection is suppressed.
// (RULE15) During break reception the receive buffer is not loaded.
// (RULE16) Low width 10 bits or less: no interrupt, break mode and bits kept.
// (RULE17) Baud generator has a clock selector and two independent 8-bit counters.
// (RULE18) Base clock runs only while power is enabled, held low otherwise.
// (RULE19) Transmit counter held at zero unless power and transmit enabled.
// (RULE20) Transmit counter clears on first buffer write and back-to-back frame ends.
// (RULE21) Receive counter cleared when off; runs from start bit for one frame.
// (RULE22) Four-bit select picks counter clock; eight-bit field sets the divisor.
// (RULE23) Bit rate is base clock over twice the divisor, divisor 8 to 255.
// (RULE24) On overrun the new byte is not copied into the receive buffer.
module ureb_top
    import ureb_pkg::*;
#(
    parameter int unsigned DIV_W = 8
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serialInPin,
    input  wire logic        txFrameDone,
    output logic             rxDoneIrq,
    output logic             rxErrIrq,
    output logic             txBaudTick,
    output logic      [7:0]  txData
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]         mode_q;
    logic [3:0]         ckSel_q;
    logic [DIV_W-1:0]   baud_q;
    logic [7:0]         rxBuf_q;
    logic               rxFull_q;
    ureb_err_t          errStat_q;
    ureb_err_t          errStat_d;
    logic               brkTrig_q;
    logic               brkFlag_q;
    logic [7:0]         txBuf_q;
    logic               txBusy_q;
    logic               txPending_q;
    logic [31:0]        prdata_q;
    logic [PRESC_W-1:0] presc_q;
    logic               samp0_q;
    logic               samp1_q;
    logic               filt_q;
    logic               filtPrev_q;
    ureb_rxstate_t      state_q;
    logic               half_q;
    logic [2:0]         bitCnt_q;
    logic [7:0]         rxShift_q;
    logic               parBit_q;
    logic               rxDone_q;
    logic               rxErr_q;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Zero wait states: the read word is captured in the setup cycle.
    wire setupRd   = psel && !penable && !pwrite;
    wire access    = psel && penable;
    wire wrEn      = access && pwrite;
    wire rdEn      = access && !pwrite;
    wire selMode   = (paddr == OFF_MODE);
    wire selErrSt  = (paddr == OFF_ERRST);
    wire selCtrl   = (paddr == OFF_CTRL);
    wire selCkSel  = (paddr == OFF_CKSEL);
    wire selBaud   = (paddr == OFF_BAUD);
    wire selRxBuf  = (paddr == OFF_RXBUF);
    wire selTxBuf  = (paddr == OFF_TXBUF);
    wire mapped    = selMode | selErrSt | selCtrl | selCkSel | selBaud | selRxBuf | selTxBuf;
    wire [31:0] rdMux = selMode  ? {24'h0, mode_q} :
                        selErrSt ? {29'h0, errStat_q} :
                        selCtrl  ? {24'h0, brkFlag_q, brkTrig_q, 6'h0} :
                        selCkSel ? {28'h0, ckSel_q} :
                        selBaud  ? {{(32-DIV_W){1'b0}}, baud_q} :
                        selRxBuf ? {24'h0, rxBuf_q} : 32'h0;
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = prdata_q;

    // Mode fields.
    wire powerOn  = mode_q[MODE_POWER_BIT];
    wire txOn     = powerOn && mode_q[MODE_TXE_BIT];
    wire rxOn     = powerOn && mode_q[MODE_RXE_BIT];
    wire mergeSel = mode_q[MODE_MERGE_BIT];
    ureb_parity_t parMode;
    assign parMode = ureb_parity_t'(mode_q[MODE_PAR_LSB+1:MODE_PAR_LSB]);

    // ------------------------------------------------------------------
    // Base clock select and prescaler
    // ------------------------------------------------------------------
    // The base clock is a one-cycle tick every 2^selEff clocks; a tick instead of
    // a gated clock keeps the whole block in one domain.
    wire [3:0]         selEff    = (ckSel_q > CKSEL_MAX) ? CKSEL_MAX : ckSel_q;   // RULE22
    wire [PRESC_W-1:0] prescMask = ~({PRESC_W{1'b1}} << selEff);
    wire               baseTick  = powerOn && ((presc_q & prescMask) == prescMask); // RULE18

    always_ff @(posedge clk) begin
        if (rst || !powerOn) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + PRESC_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Noise filter
    // ------------------------------------------------------------------
    // Two base-clock samples must agree before the filtered level moves,
    // which costs two base clocks of latency.
    always_ff @(posedge clk) begin
        if (rst) begin
            samp0_q    <= 1'b1;
            samp1_q    <= 1'b1;
            filt_q     <= 1'b1;
            filtPrev_q <= 1'b1;
        end else if (baseTick) begin
            samp0_q    <= serialInPin;                                  // RULE8
            samp1_q    <= samp0_q;
            filt_q     <= (samp0_q == samp1_q) ? samp1_q : filt_q;      // RULE7
            filtPrev_q <= filt_q;
        end
    end

    // ------------------------------------------------------------------
    // Baud counters
    // ------------------------------------------------------------------
    logic             rxWrap;
    logic             txWrap;
    logic [DIV_W-1:0] rxCount;
    logic [DIV_W-1:0] txCount;
    wire rxRun   = (state_q != RX_IDLE) && (state_q != RX_BRKW);        // RULE21
    wire rxClear = !rxOn || !rxRun;                                     // RULE21
    wire txFirst = wrEn && selTxBuf && !txBusy_q;
    wire txClear = !txOn || txFirst || (txFrameDone && txPending_q);    // RULE19 RULE20

    ureb_baud_counter #(.WIDTH(DIV_W)) u_rxCnt (                        // RULE17
        .clk     (clk),
        .rst     (rst),
        .clear   (rxClear),
        .run     (rxRun),
        .tick    (baseTick),
        .divisor (baud_q),
        .count   (rxCount),
        .wrap    (rxWrap)
    );

    ureb_baud_counter #(.WIDTH(DIV_W)) u_txCnt (                        // RULE17
        .clk     (clk),
        .rst     (rst),
        .clear   (txClear),
        .run     (txOn),
        .tick    (baseTick),
        .divisor (baud_q),
        .count   (txCount),
        .wrap    (txWrap)
    );
    assign txBaudTick = txWrap;

    // ------------------------------------------------------------------
    // Receive sequencer
    // ------------------------------------------------------------------
    // Samples fall mid-bit: half a bit after the edge, then every full bit.
    wire sampleEv  = (state_q == RX_START) ? rxWrap : (rxWrap && half_q);     // RULE23
    wire breakMode = brkTrig_q;
    wire parXor    = ^rxShift_q ^ parBit_q;
    wire parErr    = (parMode == UREB_PAR_ODD  && !parXor) ||
                     (parMode == UREB_PAR_EVEN &&  parXor);                    // RULE1
    wire stopEv    = (state_q == RX_STOP) && sampleEv;
    wire normEnd   = stopEv && !breakMode;
    ureb_err_t newErr;
    assign newErr.parity  = normEnd && parErr;                                 // RULE1 RULE14
    assign newErr.framing = normEnd && !filt_q;                                // RULE2 RULE14
    assign newErr.overrun = normEnd && rxFull_q;                               // RULE3 RULE14
    wire anyErr    = |newErr;
    wire bufLoad   = normEnd && !rxFull_q;                                     // RULE24 RULE15
    wire brkDone   = (state_q == RX_BRKW) && filt_q;                           // RULE13

    always_ff @(posedge clk) begin
        if (rst || !rxOn) begin
            state_q   <= RX_IDLE;
            half_q    <= 1'b0;
            bitCnt_q  <= 3'h0;
            rxShift_q <= 8'h0;
            parBit_q  <= 1'b0;
        end else begin
            half_q <= rxWrap ? !half_q : half_q;
            case (state_q)
                RX_IDLE: begin
                    half_q <= 1'b0;
                    if (baseTick && filtPrev_q && !filt_q) begin
                        state_q <= RX_START;                                   // RULE12
                    end
                end
                RX_START: begin
                    bitCnt_q <= 3'h0;
                    half_q   <= 1'b0;
                    if (sampleEv) begin
                        state_q <= filt_q ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (sampleEv) begin
                        rxShift_q <= {filt_q, rxShift_q[7:1]};
                        bitCnt_q  <= bitCnt_q + 3'h1;
                        if (bitCnt_q == DATA_LAST) begin
                            // Break frames always count a parity slot.
                            state_q <= (breakMode || parMode != UREB_PAR_NONE) ? RX_PAR
                                                                            : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (sampleEv) begin
                        parBit_q <= filt_q;
                        state_q  <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (sampleEv) begin
                        // Still low at 10.5 bits means a real break.
                        state_q <= (breakMode && !filt_q) ? RX_BRKW : RX_IDLE; // RULE16
                    end
                end
                RX_BRKW: begin
                    if (filt_q) begin
                        state_q <= RX_IDLE;
                    end
                end
                default: begin
                    state_q <= RX_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pulses
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rxDone_q <= 1'b0;
            rxErr_q  <= 1'b0;
        end else begin
            rxDone_q <= brkDone || (normEnd && (!anyErr || mergeSel));        // RULE6 RULE13
            rxErr_q  <= anyErr && !mergeSel;                                   // RULE4 RULE6
        end
    end
    assign rxDoneIrq = rxDone_q;
    assign rxErrIrq  = rxErr_q;

    // ------------------------------------------------------------------
    // Status and buffers
    // ------------------------------------------------------------------
    // A new error in the read cycle survives the read-clear.
    assign errStat_d = ((rdEn && selErrSt) ? ureb_err_t'(3'h0) : errStat_q) | newErr; // RULE5

    always_ff @(posedge clk) begin
        if (rst) begin
            errStat_q <= '0;
            rxBuf_q   <= RXBUF_RST;
            rxFull_q  <= 1'b0;
        end else begin
            errStat_q <= errStat_d;
            rxBuf_q   <= bufLoad ? rxShift_q : rxBuf_q;                        // RULE15
            rxFull_q  <= bufLoad || (rxFull_q && !(rdEn && selRxBuf));
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // The trigger is only armed once power and receive are on; the flag
    // marks a break frame in progress and both drop together on success.
    wire trigWr = wrEn && selCtrl && rxOn;                                     // RULE11
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q    <= MODE_RST;
            ckSel_q   <= CKSEL_RST;
            baud_q    <= BAUD_RST;
            brkTrig_q <= 1'b0;
            brkFlag_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            mode_q   <= (wrEn && selMode) ? pwdata[7:0] : mode_q;
            ckSel_q  <= (wrEn && selCkSel) ? pwdata[3:0] : ckSel_q;
            baud_q   <= (wrEn && selBaud) ? pwdata[DIV_W-1:0] : baud_q;        // RULE22
            prdata_q <= setupRd ? rdMux : prdata_q;
            if (brkDone || !rxOn) begin
                brkTrig_q <= 1'b0;                                             // RULE13
                brkFlag_q <= 1'b0;
            end else begin
                brkTrig_q <= trigWr ? pwdata[CTRL_TRIG_BIT] : brkTrig_q;
                brkFlag_q <= brkFlag_q || (brkTrig_q && state_q == RX_START);
            end
        end
    end

    // Transmit buffer bookkeeping for the counter clear.
    always_ff @(posedge clk) begin
        if (rst || !txOn) begin
            txBuf_q     <= 8'h0;
            txBusy_q    <= 1'b0;
            txPending_q <= 1'b0;
        end else begin
            txBuf_q     <= (wrEn && selTxBuf) ? pwdata[7:0] : txBuf_q;
            txBusy_q    <= txFirst || (txBusy_q && !(txFrameDone && !txPending_q));
            txPending_q <= (wrEn && selTxBuf && txBusy_q) ||
                           (txPending_q && !txFrameDone);
        end
    end
    assign txData = txBuf_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_brk_low_at_stop;
        stopEv && breakMode && !filt_q ##1 (state_q == RX_BRKW);
    endsequence

    a_err_irq_split: assert property (anyErr |=> (rxErrIrq == !$past(mergeSel))
        && (rxDoneIrq == $past(mergeSel))) else $error("error irq routing wrong"); // RULE6
    a_status_rdclr: assert property (rdEn && selErrSt && !anyErr |=> errStat_q == 3'h0)
        else $error("status not cleared by read");                         // RULE5
    a_err_sticky: assert property (newErr.overrun |=> errStat_q.overrun)
        else $error("overrun flag lost");                                  // RULE3
    a_base_gated: assert property (!powerOn |-> !baseTick)
        else $error("base tick while power off");                          // RULE18
    a_tx_cnt_hold: assert property (!txOn |=> txCount == '0)
        else $error("tx counter not held");                                // RULE19
    a_rx_cnt_hold: assert property ((state_q == RX_IDLE) |=> rxCount == '0)
        else $error("rx counter runs when idle");                          // RULE21
    a_brk_no_load: assert property (breakMode |=> $stable(rxBuf_q) && $stable(errStat_q[0]))
        else $error("buffer or overrun touched in break");                 // RULE15 RULE14
    a_ovr_no_write: assert property (normEnd && rxFull_q |=> $stable(rxBuf_q))
        else $error("buffer overwritten on overrun");                      // RULE24
    a_filter_agree: assert property (baseTick && (samp0_q != samp1_q) |=> $stable(filt_q))
        else $error("filter moved on disagreement");                       // RULE7
    a_brk_done_clr: assert property (s_brk_low_at_stop ##[0:1000] brkDone |=> rxDoneIrq
        && !brkTrig_q && !brkFlag_q) else $error("break end not signalled"); // RULE13
    a_brk_short: assert property (stopEv && breakMode && filt_q |=> !rxDoneIrq && !rxErrIrq
        && brkTrig_q) else $error("short break handled wrong");            // RULE16

endmodule

// file: tb/ureb_remote_node.sv
// Remote serial node model that shifts a bit pattern onto the receive pin.
`timescale 1ns/1ps
module ureb_remote_node #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [15:0] pattern,
    input  wire logic [4:0]  nBits,
    output logic             line,
    output logic             busy
);
    int cnt = 0;
    int idx = 0;
    initial begin
        line = 1'b1;
        busy = 1'b0;
    end
    // Bits leave LSB first; the line idles high, as the pull-up would hold it.
    // A break is an all-zero pattern that is longer than one frame.
    always @(posedge clk) begin
        if (!busy && go) begin
            busy <= 1'b1;
            idx  <= 0;
            cnt  <= 0;
            line <= pattern[0];
        end else if (busy && cnt == BIT_CLKS - 1) begin
            cnt <= 0;
            if (idx + 1 == int'(nBits)) begin
                busy <= 1'b0;
                line <= 1'b1;
            end else begin
                idx  <= idx + 1;
                line <= pattern[idx+1];
            end
        end else if (busy) begin
            cnt <= cnt + 1;
        end
    end
endmodule

// file: tb/uart_rx_error_lin_break_baud_gen_bench.sv
// Self-checking bench for the receive error, break and baud generator block.
`timescale 1ns/1ps
module uart_rx_error_lin_break_baud_gen_bench
    import ureb_pkg::*;
;
    typedef struct {logic [7:0] mode; logic [15:0] pat; logic [4:0] n;
                    logic [31:0] st; int dn; int er; logic [31:0] buf8;} ureb_row_t;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, txFrameDone = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, lastErr, serialInPin, rxDoneIrq, rxErrIrq, txBaudTick;
    logic [7:0] txData;
    logic [15:0] pat = '0;
    logic [4:0] nb = '0;
    int miscompares = 0, check_count = 0, nDone, nErr, n;
    ureb_row_t rows [5];
    always #5 clk = ~clk;
    ureb_top u_ureb_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serialInPin(serialInPin), .txFrameDone(txFrameDone),
        .rxDoneIrq(rxDoneIrq), .rxErrIrq(rxErrIrq), .txBaudTick(txBaudTick), .txData(txData));
    ureb_remote_node u_ureb_remote_node (.clk(clk), .go(go), .pattern(pat), .nBits(nb),
        .line(serialInPin), .busy());
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request is held until pready is seen high; only then is it released.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog may end a wait that never sees pready.
        do begin @(posedge clk); end while (pready !== 1'b1);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        chk(q, exp);
    endtask
    // Sampling 1 ns after the edge keeps clear of the registers' own updates.
    task automatic send(input logic [15:0] p, input logic [4:0] bits);
        pat <= p;
        nb <= bits;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        nDone = 0;
        nErr = 0;
        repeat (400) begin
            @(posedge clk); #1;
            if (rxDoneIrq === 1'b1) nDone++;
            if (rxErrIrq === 1'b1) nErr++;
        end
    endtask
    // A frame run lasts about 400 cycles; this span is several times the whole run.
    initial begin
        #(20000 * 10);
        miscompares++;
        close_out();
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rows[0] = '{8'ha0, 16'h034a, 5'd10, 32'h0, 1, 0, 32'ha5};
        rows[1] = '{8'hb8, 16'h0606, 5'd11, 32'h4, 0, 1, 32'h03};
        rows[2] = '{8'ha1, 16'h00b4, 5'd10, 32'h2, 1, 0, 32'h5a};
        rows[3] = '{8'hb0, 16'h0402, 5'd11, 32'h0, 1, 0, 32'h01};
        rows[4] = '{8'ha8, 16'h061e, 5'd11, 32'h0, 1, 0, 32'h0f};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdc(OFF_BAUD, 32'hff);
        rdc(OFF_RXBUF, 32'hff);
        rdc(12'h1fc, 32'h0);
        chk(lastErr, 1'b1);
        apb(1'b1, OFF_BAUD, 32'h8);
        apb(1'b1, OFF_CKSEL, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, OFF_MODE, rows[i].mode);
            send(rows[i].pat, rows[i].n);
            chk(nDone, rows[i].dn);
            chk(nErr, rows[i].er);
            rdc(OFF_ERRST, rows[i].st);
            rdc(OFF_RXBUF, rows[i].buf8);
        end
        send(16'h034a, 5'd10);
        send(16'h023c, 5'd10);
        chk(nErr, 1);
        rdc(OFF_ERRST, 32'h1);
        rdc(OFF_ERRST, 32'h0);
        rdc(OFF_RXBUF, 32'ha5);
        apb(1'b1, OFF_MODE, 32'h80);
        apb(1'b1, OFF_CTRL, 32'h40);
        rdc(OFF_CTRL, 32'h0);
        apb(1'b1, OFF_MODE, 32'ha0);
        apb(1'b1, OFF_CTRL, 32'h40);
        send(16'h0, 5'd10);
        chk(nDone + nErr, 0);
        rdc(OFF_CTRL, 32'hc0);
        send(16'h0, 5'd13);
        chk(nDone, 1);
        chk(nErr, 0);
        rdc(OFF_CTRL, 32'h0);
        rdc(OFF_ERRST, 32'h0);
        rdc(OFF_RXBUF, 32'ha5);
        apb(1'b1, OFF_MODE, 32'hc0);
        apb(1'b1, OFF_TXBUF, 32'h55);
        #1;
        chk(txData, 8'h55);
        n = 0;
        while (txBaudTick !== 1'b1 && n < 100) begin @(posedge clk); #1; n++; end
        n = 0;
        do begin @(posedge clk); #1; n++; end while (txBaudTick !== 1'b1 && n < 100);
        chk(n, 8);
        // A byte written while busy is pending, so its frame end restarts the count.
        apb(1'b1, OFF_TXBUF, 32'h5a);
        txFrameDone <= 1'b1;
        @(posedge clk);
        txFrameDone <= 1'b0;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (txBaudTick !== 1'b1 && n < 100);
        chk(n, 7);
        apb(1'b1, OFF_MODE, 32'h80);
        n = 0;
        repeat (40) begin @(posedge clk); #1; if (txBaudTick !== 1'b0) n++; end
        chk(n, 0);
        close_out();
    end
endmodule
